// ==== verilog/uiq_pkg.sv ====
// shared constants and types of the interpolated quadrature output block
package uiq_pkg;
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_POS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CTRL_W = 5;
  localparam int CTRL_IP_LSB = 0;
  localparam int CTRL_FAST_BIT = 3;
  localparam int CTRL_EN_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h10;
  localparam logic [2:0] IP_NONE = 3'h0;
  localparam logic [2:0] IP_X5 = 3'h1;
  localparam logic [2:0] IP_X10 = 3'h2;
  localparam logic [2:0] IP_X25 = 3'h3;
  localparam logic [2:0] IP_X50 = 3'h4;
  localparam logic [2:0] IP_X100 = 3'h5;
  // fine steps (quarter of one hundredth period) per output edge
  localparam logic [6:0] DIV_NONE = 7'h64;
  localparam logic [6:0] DIV_X5 = 7'h14;
  localparam logic [6:0] DIV_X10 = 7'h0a;
  localparam logic [6:0] DIV_X25 = 7'h04;
  localparam logic [6:0] DIV_X50 = 7'h02;
  localparam logic [6:0] DIV_X100 = 7'h01;
  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_OVERSPEED = 1;
  localparam int IRQ_REF = 2;
  localparam int IRQ_PROG = 3;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int GAP_NONE_NS = 500;
  localparam int GAP_SLOW_NS = 250;
  localparam int GAP_FAST5_NS = 63;
  localparam int GAP_FAST_NS = 42;
  localparam logic [3:0] GAP_NONE_CYC = 4'((GAP_NONE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] GAP_SLOW_CYC = 4'((GAP_SLOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] GAP_FAST5_CYC = 4'((GAP_FAST5_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] GAP_FAST_CYC = 4'((GAP_FAST_NS + CLK_NS - 1) / CLK_NS);
  // ----------------------------------------
  // held steps and programming port
  // ----------------------------------------
  localparam int PEND_W = 12;
  localparam logic signed [11:0] PEND_MAX = 12'sh7ff;
  localparam logic signed [11:0] PEND_WARN = 12'sh010;
  localparam logic [2:0] PG_LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    PG_IDLE = 3'h1,
    PG_SHIFT = 3'h2,
    PG_ACK = 3'h4
  } uiq_pg_t;
endpackage

// ==== verilog/uiq_pacer.sv ====
// edge pacer: gray-order quadrature stepping with a minimum edge gap
`timescale 1ns/1ns
module uiq_pacer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic dir_up,
  input wire logic [3:0] gap,
  output logic take,
  output logic [1:0] quad
);
  import uiq_pkg::*;

  logic [3:0] wait_q, wait_d;
  logic [1:0] quad_q, quad_d;

  // a leads b when moving up: 00 10 11 01
  function automatic logic [1:0] gray_next(input logic [1:0] q, input logic up);
    case ({up, q})
      3'b100: gray_next = 2'b10;
      3'b110: gray_next = 2'b11;
      3'b111: gray_next = 2'b01;
      3'b101: gray_next = 2'b00;
      3'b000: gray_next = 2'b01;
      3'b001: gray_next = 2'b11;
      3'b011: gray_next = 2'b10;
      default: gray_next = 2'b00;
    endcase
  endfunction

  always_comb begin
    take = req && (wait_q == 4'h0);
    quad_d = take ? gray_next(quad_q, dir_up) : quad_q;
    if (take) begin
      wait_d = gap - 4'h1;
    end else if (wait_q != 4'h0) begin
      wait_d = wait_q - 4'h1;
    end else begin
      wait_d = 4'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q <= 4'h0;
      quad_q <= 2'b00;
    end else begin
      wait_q <= wait_d;
      quad_q <= quad_d;
    end
  end

  assign quad = quad_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] since_q;
  logic [3:0] gap_last_q;
  logic seen_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_q <= 5'h0;
      gap_last_q <= 4'h0;
      seen_q <= 1'b0;
    end else begin
      since_q <= take ? 5'h0 : (since_q == 5'h1f ? since_q : since_q + 5'h1);
      gap_last_q <= take ? gap : gap_last_q;
      seen_q <= seen_q | take;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_edge_gap_kept: assert property (
    take && seen_q |-> {1'b0, since_q} + 6'h01 >= {2'b00, gap_last_q})
    else $error("output edges closer than the selected gap");
  a_single_channel: assert property (
    $changed(quad_q) |-> $countones(quad_q ^ $past(quad_q)) == 1)
    else $error("both quadrature channels moved at once");
  a_take_moves_quad: assert property (
    take |=> quad_q != $past(quad_q))
    else $error("accepted step produced no edge");
endmodule

// ==== verilog/uiq_top.sv ====
// interpolated quadrature output block with axi4-lite registers
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
// ----------------------------------------
// Function
// - edge rate capped by selected frequency setting
// - interpolation none, 5, 10, 25, 50, 100
// - speed above limit flagged as overspeed
// - minimum gap enforced between successive output edges
// - ok-high fault line low when out of tolerance
// - fault given both true and complemented
// - two counting channels, complementary, quarter period apart
// - reference mark on its own complementary pair
// - square-wave outputs, interpolation up to hundredfold
// ----------------------------------------
module uiq_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uiq_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uiq_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fine_step,
  input wire logic fine_dir,
  input wire logic scan_ok,
  input wire logic ref_in,
  input wire logic prog_scl,
  input wire logic prog_sda_i,
  output logic prog_sda_o,
  output logic prog_sda_oe,
  output logic count_a_pos,
  output logic count_a_neg,
  output logic count_b_pos,
  output logic count_b_neg,
  output logic ref_mark_pos,
  output logic ref_mark_neg,
  output logic fault_true,
  output logic fault_inverted_ok_high,
  output logic irq
);
  import uiq_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // out-of-range codes fall back to the coarsest setting
  function automatic logic [6:0] step_div(input logic [2:0] ip);
    case (ip)
      IP_X5: step_div = DIV_X5;
      IP_X10: step_div = DIV_X10;
      IP_X25: step_div = DIV_X25;
      IP_X50: step_div = DIV_X50;
      IP_X100: step_div = DIV_X100;
      default: step_div = DIV_NONE;
    endcase
  endfunction

  function automatic logic [3:0] gap_cycles(input logic [2:0] ip, input logic fast);
    if (ip == IP_NONE || ip > IP_X100) begin
      gap_cycles = GAP_NONE_CYC;
    end else if (!fast) begin
      gap_cycles = GAP_SLOW_CYC;
    end else if (ip == IP_X5) begin
      gap_cycles = GAP_FAST5_CYC;
    end else begin
      gap_cycles = GAP_FAST_CYC;
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_fire;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d, irq_clr, ev;
  logic irq_q, irq_d;
  logic signed [7:0] presc_q, presc_d, presc_n, div_s;
  logic signed [11:0] pend_q, pend_d, pend_n, inc, dec;
  logic [15:0] pos_q, pos_d;
  logic ovs_q, ovs_d, fault_q, fault_d;
  logic take, en;
  logic [1:0] quad;
  logic [2:0] ip;
  uiq_pg_t pg_q, pg_d;
  logic [2:0] pg_cnt_q, pg_cnt_d;
  logic [7:0] pg_sh_q, pg_sh_d;
  logic scl_q, sda_q, pg_oe_q, pg_oe_d, pg_wr;
  logic scl_rise, pg_start;
  logic [6:0] out_q, out_d;

  assign ip = ctrl_q[CTRL_IP_LSB +: 3];
  assign en = ctrl_q[CTRL_EN_BIT];

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  always_comb begin
    s_axi_awready = !aw_have_q && !bvalid_q;
    s_axi_wready = !w_have_q && !bvalid_q;
    s_axi_arready = !rvalid_q;
    wr_fire = aw_have_q && w_have_q;
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      case (aw_addr_q)
        ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN,
        ADDR_POS: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_d = {27'h0, ctrl_q};
        ADDR_STATUS: rdata_d = {4'h0, pend_q, 10'h0, quad, 2'h0, ovs_q, fault_q};
        ADDR_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
        ADDR_IRQ_CLR: rdata_d = 32'h0;
        ADDR_IRQ_EN: rdata_d = {28'h0, irq_en_q};
        ADDR_POS: rdata_d = {16'h0, pos_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h0;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // settings and interrupts
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    irq_clr = '0;
    // the bus write wins over a programming byte landing in the same cycle
    if (pg_wr) begin
      ctrl_d = pg_sh_q[CTRL_W-1:0];
    end
    if (wr_fire && wstrb0_q) begin
      case (aw_addr_q)
        ADDR_CTRL: ctrl_d = wdata_q[CTRL_W-1:0];
        ADDR_IRQ_EN: irq_en_d = wdata_q[IRQ_W-1:0];
        ADDR_IRQ_CLR: irq_clr = wdata_q[IRQ_W-1:0];
        default: ctrl_d = ctrl_d;
      endcase
    end
    ev = '0;
    ev[IRQ_FAULT] = fault_d && !fault_q;
    ev[IRQ_OVERSPEED] = ovs_d && !ovs_q;
    ev[IRQ_REF] = ref_in;
    ev[IRQ_PROG] = pg_wr;
    // a new event beats a clear in the same cycle
    irq_stat_d = (irq_stat_q & ~irq_clr) | ev;
    irq_d = |(irq_stat_d & irq_en_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      irq_en_q <= IRQ_EN_RST;
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_en_q <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  // ----------------------------------------
  // step division and held steps
  // ----------------------------------------
  always_comb begin
    div_s = $signed({1'b0, step_div(ip)});
    presc_n = fine_dir ? presc_q + 8'sh01 : presc_q - 8'sh01;
    presc_d = presc_q;
    inc = 12'sh000;
    if (!en) begin
      presc_d = 8'sh00;
    end else if (fine_step) begin
      if (presc_n == div_s) begin
        presc_d = 8'sh00;
        inc = 12'sh001;
      end else if (presc_n == -div_s) begin
        presc_d = 8'sh00;
        inc = -12'sh001;
      end else begin
        presc_d = presc_n;
      end
    end
    dec = take ? ((pend_q > 12'sh000) ? 12'sh001 : -12'sh001) : 12'sh000;
    // steps beyond the held range are lost; overspeed already flagged by then
    if ((pend_q == PEND_MAX && inc > 12'sh000) || (pend_q == -PEND_MAX && inc < 12'sh000)) begin
      pend_n = pend_q - dec;
    end else begin
      pend_n = pend_q + inc - dec;
    end
    pend_d = en ? pend_n : 12'sh000;
    pos_d = take ? ((pend_q > 12'sh000) ? pos_q + 16'h1 : pos_q - 16'h1) : pos_q;
    ovs_d = (pend_d >= PEND_WARN) || (pend_d <= -PEND_WARN);
    fault_d = !scan_ok;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= 8'sh00;
      pend_q <= 12'sh000;
      pos_q <= 16'h0;
      ovs_q <= 1'b0;
      fault_q <= 1'b1;
    end else begin
      presc_q <= presc_d;
      pend_q <= pend_d;
      pos_q <= pos_d;
      ovs_q <= ovs_d;
      fault_q <= fault_d;
    end
  end

  uiq_pacer u_pacer (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(en && pend_q != 12'sh000),
    .dir_up(pend_q > 12'sh000),
    .gap(gap_cycles(ip, ctrl_q[CTRL_FAST_BIT])),
    .take(take),
    .quad(quad)
  );

  // ----------------------------------------
  // programming port
  // ----------------------------------------
  always_comb begin
    scl_rise = prog_scl && !scl_q;
    pg_start = prog_scl && scl_q && sda_q && !prog_sda_i;
    pg_d = pg_q;
    pg_cnt_d = pg_cnt_q;
    pg_sh_d = pg_sh_q;
    pg_wr = 1'b0;
    case (pg_q)
      PG_IDLE: begin
        if (pg_start) begin
          pg_d = PG_SHIFT;
          pg_cnt_d = 3'h0;
        end
      end
      PG_SHIFT: begin
        if (pg_start) begin
          pg_cnt_d = 3'h0;
        end else if (scl_rise) begin
          pg_sh_d = {pg_sh_q[6:0], prog_sda_i};
          pg_cnt_d = pg_cnt_q + 3'h1;
          if (pg_cnt_q == PG_LAST_BIT) begin
            pg_d = PG_ACK;
          end
        end
      end
      PG_ACK: begin
        pg_wr = 1'b1;
        pg_d = PG_IDLE;
      end
      default: pg_d = PG_IDLE;
    endcase
    // acknowledge is held low from the byte's end to the next clock rise
    pg_oe_d = (pg_d == PG_ACK) || (pg_oe_q && !scl_rise);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pg_q <= PG_IDLE;
      pg_cnt_q <= 3'h0;
      pg_sh_q <= 8'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pg_oe_q <= 1'b0;
    end else begin
      pg_q <= pg_d;
      pg_cnt_q <= pg_cnt_d;
      pg_sh_q <= pg_sh_d;
      scl_q <= prog_scl;
      sda_q <= prog_sda_i;
      pg_oe_q <= pg_oe_d;
    end
  end

  assign prog_sda_o = 1'b0;
  assign prog_sda_oe = pg_oe_q;

  // ----------------------------------------
  // line drivers
  // ----------------------------------------
  always_comb begin
    out_d[0] = quad[1];
    out_d[1] = quad[0];
    out_d[2] = ref_in;
    out_d[3] = !scan_ok;
    out_d[6:4] = 3'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 7'h08;
    end else begin
      out_q <= out_d;
    end
  end

  assign count_a_pos = out_q[0];
  assign count_a_neg = !out_q[0];
  assign count_b_pos = out_q[1];
  assign count_b_neg = !out_q[1];
  assign ref_mark_pos = out_q[2];
  assign ref_mark_neg = !out_q[2];
  assign fault_true = out_q[3];
  assign fault_inverted_ok_high = !out_q[3];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fault_low_out: assert property (
    !scan_ok |=> !fault_inverted_ok_high && fault_true)
    else $error("ok-high fault line not low after tolerance loss");
  a_fault_pair_opp: assert property (
    fault_true != fault_inverted_ok_high)
    else $error("fault lines not complementary");
  a_count_follow: assert property (
    ##1 {count_a_pos, count_b_pos} == $past(quad) && count_a_neg != count_a_pos)
    else $error("counting pair does not follow the pacer");
  a_ref_mark_pair: assert property (
    ref_in |=> ref_mark_pos && !ref_mark_neg)
    else $error("reference pair did not show the mark");
  a_pend_held: assert property (
    en && pend_q != 12'sh000 && !take && !fine_step |=> pend_q == $past(pend_q))
    else $error("held steps changed without an edge");
  a_overspeed_flag: assert property (
    pend_q >= PEND_WARN |-> ovs_q)
    else $error("overspeed not flagged with steps held");
  a_prog_write: assert property (
    pg_wr && !(wr_fire && wstrb0_q && aw_addr_q == ADDR_CTRL)
      |=> ctrl_q == $past(pg_sh_q[CTRL_W-1:0]))
    else $error("programming byte did not reach the settings");
  a_none_divides: assert property (
    en && fine_step && inc != 12'sh000 |-> presc_n == div_s || presc_n == -div_s)
    else $error("output step not at the divider boundary");
  a_irq_set_wins: assert property (
    ref_in && irq_clr[IRQ_REF] |=> irq_stat_q[IRQ_REF])
    else $error("clear swallowed a same-cycle event");
endmodule

// ==== tb/uiq_counter.sv ====
// far-side model: fourfold up/down counter on the quadrature pairs
`timescale 1ns/1ns
module uiq_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic a_pos,
  input wire logic a_neg,
  input wire logic b_pos,
  input wire logic b_neg,
  output int count,
  output int faults,
  output logic edge_seen
);
  logic [1:0] last_q;
  // sampled at 25 mhz, above the fastest setting's minimum counter clock
  always @(posedge aclk) begin
    edge_seen <= 1'b0;
    if (!aresetn) begin
      last_q <= 2'b00;
      count <= 0;
      faults <= 0;
    end else begin
      if (a_neg !== ~a_pos || b_neg !== ~b_pos) begin
        faults <= faults + 1;
      end
      if ({a_pos, b_pos} != last_q) begin
        edge_seen <= 1'b1;
        last_q <= {a_pos, b_pos};
        // every edge of both channels counts, direction from phase order
        case ({last_q, a_pos, b_pos})
          4'b0010, 4'b1011, 4'b1101, 4'b0100: count <= count + 1;
          4'b1000, 4'b1110, 4'b0111, 4'b0001: count <= count - 1;
          default: faults <= faults + 1;
        endcase
      end
    end
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the interpolated quadrature output block
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import uiq_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_arvalid = 0, s_axi_rready = 0, fine_step = 0, fine_dir = 0, scan_ok = 1;
  logic ref_in = 0, prog_scl = 1, tb_sda = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, prog_sda_o, prog_sda_oe, irq, edge_seen;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic count_a_pos, count_a_neg, count_b_pos, count_b_neg, ref_mark_pos, ref_mark_neg;
  logic fault_true, fault_inverted_ok_high;
  logic [3:0] exp_gap = 0;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [7:0] pbyte = 8'h0b;
  logic [6:0] divs[6] = '{DIV_NONE, DIV_X5, DIV_X10, DIV_X25, DIV_X50, DIV_X100};
  int bad_count = 0, tests_run = 0, cnt, faults, exp_cnt = 0, since = 0, cycles = 0, seed;
  // released sda is pulled up; the block only ever pulls it low
  wire prog_sda_i = prog_sda_oe ? 1'b0 : tb_sda;

  always #20 aclk = ~aclk;

  uiq_top dut (.*);
  uiq_counter far (.aclk, .aresetn, .a_pos(count_a_pos), .a_neg(count_a_neg),
    .b_pos(count_b_pos), .b_neg(count_b_neg), .count(cnt), .faults, .edge_seen);

  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // bus and pin drivers
  // ----------------------------------------
  // handshakes are sampled at the falling edge, where the outputs have settled
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] rs);
    logic ta, tw, tk;
    exp_q.push_back({rs, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tk = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] rs);
    logic ta, tk;
    exp_q.push_back({rs, d});
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tk = s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic steps(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      fine_step <= 1'b1;
      fine_dir <= up;
      if ($urandom_range(0, 1)) begin
        @(posedge aclk);
        fine_step <= 1'b0;
      end
    end
    @(posedge aclk);
    fine_step <= 1'b0;
  endtask

  task automatic settle();
    for (int i = 0; i < 2000 && cnt != exp_cnt; i++) @(posedge aclk);
    @(negedge aclk);
    `CHK(cnt, exp_cnt)
    rd(ADDR_POS, 32'(16'(exp_cnt)), RESP_OKAY);
  endtask

  task automatic pgs(input logic d, input logic c);
    @(posedge aclk);
    tb_sda <= d;
    prog_scl <= c;
    repeat (2) @(posedge aclk);
  endtask

  // ----------------------------------------
  // watchers
  // ----------------------------------------
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, e)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      e = exp_q.pop_front();
      `CHK({s_axi_bresp, 32'h0}, e)
    end
    if (edge_seen === 1'b1) begin
      `CHK(since >= int'(exp_gap), 1'b1)
      since = 1;
    end else begin
      since++;
    end
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    seed = $urandom(32'h4697bb19);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, 32'(CTRL_RST), RESP_OKAY);
    rd(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h1, RESP_SLVERR);
    for (int m = 0; m < 12; m++) begin
      exp_gap = m < 6 ? (m == 0 ? GAP_NONE_CYC : GAP_SLOW_CYC) :
        (m == 6 ? GAP_NONE_CYC : (m == 7 ? GAP_FAST5_CYC : GAP_FAST_CYC));
      wr(ADDR_CTRL, {27'h0, 1'b1, m >= 6, 3'(m % 6)}, RESP_OKAY);
      steps(3 * divs[m % 6], 1'b1);
      exp_cnt += 3;
      settle();
      steps(3 * divs[m % 6], 1'b0);
      exp_cnt -= 3;
      settle();
    end
    wr(ADDR_CTRL, 32'h15, RESP_OKAY);
    exp_gap = GAP_SLOW_CYC;
    wr(ADDR_IRQ_EN, 32'hf, RESP_OKAY);
    wr(ADDR_IRQ_CLR, 32'hf, RESP_OKAY);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    steps(40, 1'b1);
    exp_cnt += 40;
    @(negedge aclk);
    `CHK(irq, 1'b1)
    rd(ADDR_IRQ_STAT, 32'h2, RESP_OKAY);
    settle();
    wr(ADDR_IRQ_CLR, 32'h2, RESP_OKAY);
    wr(ADDR_IRQ_EN, 32'h4, RESP_OKAY);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    @(posedge aclk);
    scan_ok <= 1'b0;
    repeat (2) @(negedge aclk);
    `CHK({fault_true, fault_inverted_ok_high, irq}, 3'b100)
    rd(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    scan_ok <= 1'b1;
    ref_in <= 1'b1;
    @(posedge aclk);
    ref_in <= 1'b0;
    @(negedge aclk);
    `CHK({ref_mark_pos, ref_mark_neg, fault_inverted_ok_high}, 3'b101)
    @(negedge aclk);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_CLR, 32'hf, RESP_OKAY);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    @(posedge aclk);
    ref_in <= 1'b1;
    wr(ADDR_IRQ_CLR, 32'h4, RESP_OKAY);
    ref_in <= 1'b0;
    rd(ADDR_IRQ_STAT, 32'h4, RESP_OKAY);
    wr(ADDR_IRQ_CLR, 32'h4, RESP_OKAY);
    pgs(1'b0, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      pgs(tb_sda, 1'b0);
      pgs(pbyte[i], 1'b0);
      pgs(pbyte[i], 1'b1);
    end
    @(negedge aclk);
    `CHK({prog_sda_oe, prog_sda_o}, 2'b10)
    pgs(1'b1, 1'b0);
    pgs(1'b1, 1'b1);
    @(negedge aclk);
    `CHK(prog_sda_oe, 1'b0)
    @(posedge aclk);
    s_axi_wstrb <= 4'he;
    wr(ADDR_CTRL, 32'h1f, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ADDR_CTRL, 32'h0b, RESP_OKAY);
    rd(ADDR_IRQ_STAT, 32'h8, RESP_OKAY);
    `CHK(faults, 0)
    end_of_test();
  end
endmodule
